// ===== design/mtc_muting_ctrl.sv
// muting timing control with avalon register slave
`default_nettype none
`timescale 1ns/1ns
module mtc_muting_ctrl #(
    parameter int unsigned CYC_PER_MS = mtc_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // pins
    input  wire logic        muting_sensor_first,
    input  wire logic        muting_sensor_fourth,
    input  wire logic        field_interrupted,
    input  wire logic        muting_enable_in,
    input  wire logic        timer_hold,
    // result
    output logic             muting_active
);
    typedef enum logic [2:0] {
        S_IDLE, S_ONE_ON, S_MUTED, S_LAG, S_WAIT_CLEAR
    } mtc_state_t;

    localparam int DW = $clog2(CYC_PER_MS);

    mtc_state_t  state, next_state;       // muting sequence
    logic [4:0]  pin_s;                   // synchronised pins
    logic [DW-1:0] div_cnt;               // ms divider
    logic        tick;                    // one pulse per ms
    logic [1:0]  ctrl;                    // control register
    logic [19:0] limit;                   // muting_duration_limit
    logic [15:0] lag;                     // muting_lag_time
    logic [15:0] ffd;                     // field_free_end_delay
    logic [15:0] min_gap;                 // min_pair_activation_gap
    logic [15:0] max_gap;                 // max_pair_activation_gap
    logic [19:0] lim_cnt;                 // elapsed muting time
    logic [15:0] ev_cnt, next_ev;         // gap, delay or lag count
    logic        timeout_flag, reject_flag;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    wire s1       = pin_s[0];
    wire s4       = pin_s[1];
    wire field_s  = pin_s[2];
    wire en_s     = pin_s[3];
    wire hold_s   = pin_s[4];
    wire any_on   = s1 | s4;
    wire both_on  = s1 & s4;
    // enable pin only counts when configured
    wire en_ok    = !ctrl[mtc_pkg::CTRL_EN_CFG] || en_s;
    // zero limit never expires
    wire limit_hit = (limit != 20'h00000) && (lim_cnt >= limit);
    wire in_mute  = (state == S_MUTED) || (state == S_LAG);
    wire req      = avs_read | avs_write;
    wire wr       = avs_write && !avs_waitrequest;
    wire clr_st   = wr && (avs_address == mtc_pkg::OFS_STATUS);
    wire set_to   = in_mute && limit_hit;
    wire set_rej  = (state == S_ONE_ON) && (next_state == S_WAIT_CLEAR);

    // saturating millisecond step
    function automatic logic [15:0] step(input logic [15:0] v,
                                         input logic t);
        step = (t && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction : step

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    mtc_sync #(.WIDTH(5)) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({timer_hold, muting_enable_in, field_interrupted,
                    muting_sensor_fourth, muting_sensor_first}),
        .sync_out (pin_s)
    );

    // ------------------------------------------------------------
    // millisecond divider
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            tick    <= (div_cnt == DW'(CYC_PER_MS - 1));
            div_cnt <= (div_cnt == DW'(CYC_PER_MS - 1)) ? '0 : div_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_ev    = ev_cnt;
        case (state)
            S_IDLE: begin
                next_ev = 16'h0000;
                if (any_on) begin
                    next_state = S_ONE_ON;
                end
            end
            S_ONE_ON: begin
                if (!any_on) begin
                    next_state = S_IDLE;
                // RULE9 gap too long
                end else if (ev_cnt > max_gap) begin
                    next_state = S_WAIT_CLEAR;
                end else if (both_on) begin
                    // RULE8 minimum gap, RULE4 RULE10 enable gate
                    if (ev_cnt >= min_gap && en_ok) begin
                        next_state = S_MUTED;
                        next_ev    = 16'h0000;
                    end else begin
                        next_state = S_WAIT_CLEAR;
                    end
                end else begin
                    next_ev = step(ev_cnt, tick);
                end
            end
            S_MUTED: begin
                // RULE13 end on expiry, RULE4 blocked by enable
                if (limit_hit || !en_ok) begin
                    next_state = S_WAIT_CLEAR;
                    next_ev    = 16'h0000;
                // RULE5 sensors ended, lag follows
                end else if (!any_on) begin
                    next_state = S_LAG;
                    next_ev    = 16'h0000;
                // RULE6 early end on free field
                end else if (ctrl[mtc_pkg::CTRL_EARLY] && !field_s) begin
                    if (ev_cnt >= ffd) begin
                        // RULE11 delay then lag
                        next_state = S_LAG;
                        next_ev    = 16'h0000;
                    end else begin
                        next_ev = step(ev_cnt, tick);
                    end
                end else begin
                    // RULE7 blocked field restarts delay
                    next_ev = 16'h0000;
                end
            end
            S_LAG: begin
                if (limit_hit || !en_ok) begin
                    next_state = S_WAIT_CLEAR;
                // RULE5 lag time done
                end else if (ev_cnt >= lag) begin
                    next_state = S_WAIT_CLEAR;
                end else begin
                    next_ev = step(ev_cnt, tick);
                end
            end
            S_WAIT_CLEAR: begin
                next_ev = 16'h0000;
                if (!any_on) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequence state and result
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state         <= S_IDLE;
            ev_cnt        <= 16'h0000;
            muting_active <= 1'b0;
        end else begin
            state         <= next_state;
            ev_cnt        <= next_ev;
            muting_active <= (next_state == S_MUTED) ||
                             (next_state == S_LAG);
        end
    end

    // ------------------------------------------------------------
    // muting duration timer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lim_cnt <= 20'h00000;
        end else if (!in_mute) begin
            lim_cnt <= 20'h00000;
        // RULE3 freeze while held, RULE2 RULE12 run when low
        end else if (tick && !hold_s && lim_cnt != 20'hfffff) begin
            lim_cnt <= lim_cnt + 20'h00001;
        end
    end

    // ------------------------------------------------------------
    // sticky status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_flag <= 1'b0;
            reject_flag  <= 1'b0;
        end else begin
            timeout_flag <= set_to ||
                (timeout_flag &&
                 !(clr_st && avs_writedata[mtc_pkg::ST_TIMEOUT]));
            reject_flag  <= set_rej ||
                (reject_flag &&
                 !(clr_st && avs_writedata[mtc_pkg::ST_REJECT]));
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl    <= mtc_pkg::CTRL_RST;
            // RULE1 ten minute default
            limit   <= mtc_pkg::LIMIT_RST;
            lag     <= mtc_pkg::LAG_RST;
            ffd     <= mtc_pkg::FFD_RST;
            min_gap <= mtc_pkg::MINGAP_RST;
            max_gap <= mtc_pkg::MAXGAP_RST;
        end else if (wr) begin
            if (avs_address == mtc_pkg::OFS_CTRL) begin
                ctrl <= avs_writedata[1:0];
            end else if (avs_address == mtc_pkg::OFS_LIMIT) begin
                limit <= avs_writedata[19:0];
            end else if (avs_address == mtc_pkg::OFS_LAG) begin
                lag <= avs_writedata[15:0];
            end else if (avs_address == mtc_pkg::OFS_FFD) begin
                ffd <= avs_writedata[15:0];
            end else if (avs_address == mtc_pkg::OFS_MINGAP) begin
                min_gap <= avs_writedata[15:0];
            end else if (avs_address == mtc_pkg::OFS_MAXGAP) begin
                max_gap <= avs_writedata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read selection, unmapped reads zero
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h00000000;
        if (avs_address == mtc_pkg::OFS_CTRL) begin
            rd_mux[1:0] = ctrl;
        end else if (avs_address == mtc_pkg::OFS_LIMIT) begin
            rd_mux[19:0] = limit;
        end else if (avs_address == mtc_pkg::OFS_LAG) begin
            rd_mux[15:0] = lag;
        end else if (avs_address == mtc_pkg::OFS_FFD) begin
            rd_mux[15:0] = ffd;
        end else if (avs_address == mtc_pkg::OFS_MINGAP) begin
            rd_mux[15:0] = min_gap;
        end else if (avs_address == mtc_pkg::OFS_MAXGAP) begin
            rd_mux[15:0] = max_gap;
        end else if (avs_address == mtc_pkg::OFS_STATUS) begin
            rd_mux[mtc_pkg::ST_ACTIVE]  = muting_active;
            rd_mux[mtc_pkg::ST_TIMEOUT] = timeout_flag;
            rd_mux[mtc_pkg::ST_REJECT]  = reject_flag;
            rd_mux[mtc_pkg::ST_HOLD]    = hold_s;
        end
    end

    // ------------------------------------------------------------
    // bus handshake: one wait cycle per access
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_held_mute;
        in_mute && hold_s && next_state == state;
    endsequence
    sequence s_ready_free;
        state == S_MUTED && !limit_hit && en_ok && any_on &&
        ctrl[mtc_pkg::CTRL_EARLY] && !field_s && ev_cnt >= ffd;
    endsequence

    AST_FREEZE: assert property (s_held_mute |=> $stable(lim_cnt)) // RULE3
        else $error("muting timer moved while held");
    AST_LIMIT_END: assert property (in_mute && limit_hit // RULE13
        |=> state == S_WAIT_CLEAR ##1 !muting_active)
        else $error("muting outlived its time limit");
    AST_UNLIMITED: assert property (limit == 20'h00000 // RULE1
        && state == S_MUTED && any_on && en_ok
        && !ctrl[mtc_pkg::CTRL_EARLY] |=> state == S_MUTED)
        else $error("zero limit ended muting");
    AST_RUN: assert property (state == S_MUTED && !hold_s && tick // RULE2
        && next_state == S_MUTED |=> lim_cnt == $past(lim_cnt) + 20'h1)
        else $error("muting timer did not run");
    AST_ENABLE: assert property (in_mute && !en_ok // RULE4
        |=> !in_mute ##1 !muting_active)
        else $error("muting kept without enable");
    AST_LAG_HOLD: assert property (state == S_LAG && ev_cnt < lag // RULE5
        && !limit_hit && en_ok |=> state == S_LAG && muting_active)
        else $error("lag time cut short");
    AST_EARLY: assert property (s_ready_free |=> state == S_LAG) // RULE6
        else $error("free field did not end muting");
    AST_REBLOCK: assert property (state == S_MUTED && field_s // RULE7
        |=> ev_cnt == 16'h0000)
        else $error("free delay not restarted");
    AST_MIN_GAP: assert property (state == S_ONE_ON && both_on // RULE8
        && ev_cnt < min_gap && ev_cnt <= max_gap |=> state == S_WAIT_CLEAR)
        else $error("pair below minimum gap accepted");
    AST_MAX_GAP: assert property (state == S_ONE_ON && any_on // RULE9
        && ev_cnt > max_gap |=> state == S_WAIT_CLEAR && reject_flag)
        else $error("pair above maximum gap accepted");
    AST_BUS: assert property (req && avs_waitrequest |=> !avs_waitrequest
        ##1 avs_waitrequest)
        else $error("bus answer not one cycle late");
endmodule : mtc_muting_ctrl
`default_nettype wire

// ===== design/mtc_pkg.sv
// constants of the muting timing control block
//
// Summary of operation
// RULE1: time limit zero means unlimited; default ten minutes
// RULE2: timer control low: end muting at limit
// RULE3: timer control high freezes timer, resumes later
// RULE4: enable input globally allows or blocks muting
// RULE5: keep muting for lag time after end
// RULE6: early end by sensors or free field
// RULE7: field blocked again restarts free delay
// RULE8: parallel pair needs minimum activation gap
// RULE9: parallel pair rejected above maximum gap
// RULE10: controller holds enable high to permit muting
// RULE11: free delay and lag time add up
// RULE12: broken timer cable reads zero, timer runs
// RULE13: limit expiry ends muting at once
`default_nettype none
package mtc_pkg;
    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10000000;   // 100 ns period
    localparam int unsigned MS_PER_S    = 1000;
    localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
    // ------------------------------------------------------------
    // times in milliseconds, as configured after reset
    // ------------------------------------------------------------
    localparam int unsigned LIMIT_MIN   = 10;         // minutes
    localparam logic [19:0] LIMIT_RST   = 20'(LIMIT_MIN * 60 * 1000);
    localparam logic [15:0] LAG_RST     = 16'h0000;   // 0 ms
    localparam logic [15:0] FFD_RST     = 16'h0000;   // 0 ms
    localparam logic [15:0] MINGAP_RST  = 16'h0000;   // 0 ms
    localparam logic [15:0] MAXGAP_RST  = 16'h09c4;   // 2500 ms
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0]  OFS_CTRL    = 5'h00;
    localparam logic [4:0]  OFS_LIMIT   = 5'h04;
    localparam logic [4:0]  OFS_LAG     = 5'h08;
    localparam logic [4:0]  OFS_FFD     = 5'h0c;
    localparam logic [4:0]  OFS_MINGAP  = 5'h10;
    localparam logic [4:0]  OFS_MAXGAP  = 5'h14;
    localparam logic [4:0]  OFS_STATUS  = 5'h18;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_EN_CFG = 0;   // enable input in use
    localparam int unsigned CTRL_EARLY  = 1;   // end on free field
    localparam int unsigned ST_ACTIVE   = 0;   // muting active
    localparam int unsigned ST_TIMEOUT  = 1;   // sticky, write 1 clears
    localparam int unsigned ST_REJECT   = 2;   // sticky, write 1 clears
    localparam int unsigned ST_HOLD     = 3;   // timer frozen
endpackage : mtc_pkg
`default_nettype wire

// ===== design/mtc_sync.sv
// two-stage synchroniser for the pin inputs
`default_nettype none
`timescale 1ns/1ns
module mtc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // pins and their synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;   // first stage, read only by second

    // ------------------------------------------------------------
    // two flip-flops per bit
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : mtc_sync
`default_nettype wire

// ===== tb/mtc_plant.sv
// far-side model: muting sensors, protective field and controller
`default_nettype none
`timescale 1ns/1ns
module mtc_plant (
    // clock
    input  wire logic clk,
    // pins towards the block
    output logic      sens_a,
    output logic      sens_b,
    output logic      field_blk,
    output logic      en_out,
    output logic      hold_out
);
    // ------------------------------------------------------------
    // pin levels at time zero
    // ------------------------------------------------------------
    // controller enable high
    initial begin
        sens_a    = 1'b0;
        sens_b    = 1'b0;
        field_blk = 1'b0;
        en_out    = 1'b1;
        hold_out  = 1'b0;
    end
    // ------------------------------------------------------------
    // stimulus tasks, all changes just after a rising edge
    // ------------------------------------------------------------
    // first sensor, second one gap clocks later
    task automatic pair(input int gap);
        @(posedge clk);
        sens_a <= 1'b1;
        repeat (gap) @(posedge clk);
        sens_b <= 1'b1;
    endtask : pair
    // both sensors fall, object has passed
    task automatic unpair();
        @(posedge clk);
        sens_a <= 1'b0;
        sens_b <= 1'b0;
    endtask : unpair
    // hold low also stands for a broken cable
    task automatic set_pins(input logic f, input logic e, input logic h);
        @(posedge clk);
        field_blk <= f;
        en_out    <= e;
        hold_out  <= h;
    endtask : set_pins
endmodule : mtc_plant
`default_nettype wire

// ===== tb/muting_timing_control_tb_top.sv
// self-checking testbench of the muting timing control block
`default_nettype none
`timescale 1ns/1ns
module muting_timing_control_tb_top;
    localparam int unsigned CPM  = 10;    // clocks per ms in simulation
    localparam int unsigned CEIL = 6000;  // timeout ceiling in clocks
    // clock, reset and bus
    logic        clk;
    logic        arst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    // pins
    logic        sa;
    logic        sb;
    logic        fld;
    logic        en;
    logic        hold;
    logic        muting_active;
    // bookkeeping
    int          errors;
    int          n_checks;
    int          cyc = 0;
    // ------------------------------------------------------------
    // design and far-side model
    // ------------------------------------------------------------
    mtc_muting_ctrl #(.CYC_PER_MS(CPM)) dut_u (
        .clk                  (clk),
        .arst_n               (arst_n),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_writedata        (avs_writedata),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .muting_sensor_first  (sa),
        .muting_sensor_fourth (sb),
        .field_interrupted    (fld),
        .muting_enable_in     (en),
        .timer_hold           (hold),
        .muting_active        (muting_active)
    );
    mtc_plant pm_u (
        .clk       (clk),
        .sens_a    (sa),
        .sens_b    (sb),
        .field_blk (fld),
        .en_out    (en),
        .hold_out  (hold)
    );
    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // cut a hang short after the ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            errors = errors + 1;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // wait a number of clocks
    task automatic wc(input int n);
        repeat (n) @(posedge clk);
    endtask : wc
    // bus write, held until waitrequest is seen low
    task automatic avw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : avw
    // bus read and compare, data taken at the answering edge
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        chk(avs_readdata, e);
        avs_read <= 1'b0;
    endtask : rd
    // muting output against expected level
    task automatic ma(input logic e);
        chk({31'h0, muting_active}, {31'h0, e});
    endtask : ma
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        arst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        // reset values and an unmapped place
        rd(mtc_pkg::OFS_CTRL, 32'h0);
        rd(mtc_pkg::OFS_LIMIT, 32'h000927c0);
        rd(mtc_pkg::OFS_LAG, 32'h0);
        rd(mtc_pkg::OFS_FFD, 32'h0);
        rd(mtc_pkg::OFS_MINGAP, 32'h0);
        rd(mtc_pkg::OFS_MAXGAP, 32'h000009c4);
        rd(5'h1c, 32'h0);
        $display("test reset values done");
        // lag time after the sensors end
        avw(mtc_pkg::OFS_LAG, 32'h5);
        pm_u.pair(3);
        wc(10);
        ma(1'b1);
        pm_u.unpair();
        wc(35);
        ma(1'b1);
        wc(40);
        ma(1'b0);
        avw(mtc_pkg::OFS_LAG, 32'h0);
        $display("test lag done");
        // maximum gap: too long refused, inside accepted
        avw(mtc_pkg::OFS_MAXGAP, 32'h3);
        pm_u.pair(60);
        wc(10);
        ma(1'b0);
        rd(mtc_pkg::OFS_STATUS, 32'h4);
        pm_u.unpair();
        avw(mtc_pkg::OFS_STATUS, 32'h4);
        rd(mtc_pkg::OFS_STATUS, 32'h0);
        pm_u.pair(20);
        wc(10);
        ma(1'b1);
        pm_u.unpair();
        wc(10);
        // minimum gap: simultaneous pair refused
        avw(mtc_pkg::OFS_MAXGAP, 32'h9c4);
        avw(mtc_pkg::OFS_MINGAP, 32'h2);
        pm_u.pair(0);
        wc(10);
        ma(1'b0);
        rd(mtc_pkg::OFS_STATUS, 32'h4);
        pm_u.unpair();
        avw(mtc_pkg::OFS_STATUS, 32'h4);
        pm_u.pair(40);
        wc(10);
        ma(1'b1);
        pm_u.unpair();
        wc(10);
        avw(mtc_pkg::OFS_MINGAP, 32'h0);
        $display("test gaps done");
        // time limit expiry with the timer running
        avw(mtc_pkg::OFS_LIMIT, 32'h4);
        pm_u.pair(0);
        wc(25);
        ma(1'b1);
        wc(35);
        ma(1'b0);
        rd(mtc_pkg::OFS_STATUS, 32'h2);
        pm_u.unpair();
        avw(mtc_pkg::OFS_STATUS, 32'h2);
        // timer frozen, then resumed from its count
        pm_u.set_pins(1'b0, 1'b1, 1'b1);
        wc(3);
        pm_u.pair(0);
        wc(80);
        ma(1'b1);
        rd(mtc_pkg::OFS_STATUS, 32'h9);
        pm_u.set_pins(1'b0, 1'b1, 1'b0);
        wc(25);
        ma(1'b1);
        // hold again: a reload would need four more ms, a resume two
        pm_u.set_pins(1'b0, 1'b1, 1'b1);
        wc(80);
        ma(1'b1);
        pm_u.set_pins(1'b0, 1'b1, 1'b0);
        wc(25);
        ma(1'b0);
        pm_u.unpair();
        avw(mtc_pkg::OFS_STATUS, 32'h2);
        // limit zero never expires
        avw(mtc_pkg::OFS_LIMIT, 32'h0);
        pm_u.pair(0);
        wc(100);
        ma(1'b1);
        pm_u.unpair();
        wc(10);
        ma(1'b0);
        $display("test limit done");
        // enable input configured
        avw(mtc_pkg::OFS_CTRL, 32'h1);
        pm_u.set_pins(1'b0, 1'b0, 1'b0);
        pm_u.pair(0);
        wc(10);
        ma(1'b0);
        pm_u.unpair();
        pm_u.set_pins(1'b0, 1'b1, 1'b0);
        avw(mtc_pkg::OFS_STATUS, 32'h6);
        pm_u.pair(0);
        wc(10);
        ma(1'b1);
        pm_u.set_pins(1'b0, 1'b0, 1'b0);
        wc(6);
        ma(1'b0);
        pm_u.unpair();
        pm_u.set_pins(1'b0, 1'b1, 1'b0);
        avw(mtc_pkg::OFS_STATUS, 32'h6);
        $display("test enable done");
        // early end on free field, delay plus lag
        avw(mtc_pkg::OFS_CTRL, 32'h2);
        avw(mtc_pkg::OFS_FFD, 32'h3);
        avw(mtc_pkg::OFS_LAG, 32'h2);
        pm_u.set_pins(1'b1, 1'b1, 1'b0);
        pm_u.pair(0);
        wc(10);
        ma(1'b1);
        pm_u.set_pins(1'b0, 1'b1, 1'b0);
        wc(12);
        pm_u.set_pins(1'b1, 1'b1, 1'b0);
        wc(60);
        ma(1'b1);
        pm_u.set_pins(1'b0, 1'b1, 1'b0);
        wc(25);
        ma(1'b1);
        wc(50);
        ma(1'b0);
        pm_u.unpair();
        wc(10);
        $display("test early end done");
        close_out();
    end
endmodule : muting_timing_control_tb_top
`default_nettype wire
